/* bgpwm_ctrl.sv */
// top: boost gate pwm timing source, overvoltage handling and phases
`timescale 1ns/1ps
// ------------------------------------------------------------
// ------------------------------------------------------------
module bgpwm_ctrl
    import bgpwm_pkg::*;
#(
    parameter int PHASES = 3 // number of gate phases
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // settings from the serial host
    input wire logic boost_enable,
    input wire logic [VTGT_W-1:0] boost_voltage_target,
    input wire logic [OVTH_W-1:0] overvoltage_threshold,
    input wire logic [HYST_W-1:0] overvoltage_reactivation_hysteresis,
    input wire logic [PHASES*LIM_W-1:0] phase_current_limit_select,
    input wire logic [SLOPE_W-1:0] slope_compensation_select,
    input wire logic fail_safe_mode,
    input wire logic [FSF_W-1:0] fail_safe_pwm_frequency,
    input wire logic sync_edge_invert,
    input wire logic [MINT_W-1:0] min_on_time_select,
    input wire logic [MINT_W-1:0] min_off_time_select,
    input wire logic [SKIP_W-1:0] skip_cycle_select,
    input wire logic status_read,
    // sync pin
    input wire logic external_sync_input,
    // comparators
    input wire logic ov_above,
    input wire logic ov_below_react,
    input wire logic [PHASES-1:0] peak_reached,
    input wire logic [PHASES-1:0] limit_trip,
    input wire logic skip_below,
    // analog settings out
    output logic [VTGT_W-1:0] voltage_target_out,
    output logic [OVTH_W-1:0] ov_threshold_out,
    output logic [HYST_W-1:0] ov_hysteresis_out,
    output logic [PHASES*LIM_W-1:0] limit_select_out,
    output logic [SLOPE_W-1:0] slope_select_out,
    output logic slope_ramp_enable,
    output logic [SKIP_W-1:0] skip_select_out,
    // gate and status
    output logic [PHASES-1:0] gate,
    output logic overvoltage_flag,
    output logic [PHASES-1:0] phase_running_flag
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [5+2*PHASES-1:0] raw_in; // async pins bundled for sync
    logic [5+2*PHASES-1:0] meta_r; // first stage, read only by stage two
    logic [5+2*PHASES-1:0] sync_r; // second stage

    assign raw_in = {external_sync_input, ov_above, ov_below_react, skip_below,
        1'b0, peak_reached, limit_trip};

    // two flops before any logic reads the comparators or the pin
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= raw_in;
            sync_r <= meta_r;
        end
    end

    logic sync_s; // synced sync pin
    logic ov_s; // synced overvoltage compare
    logic react_s; // synced reactivation compare
    logic skip_s; // synced skip compare
    logic [PHASES-1:0] peak_s; // synced peak compare
    logic [PHASES-1:0] lim_s; // synced limit compare

    assign sync_s = sync_r[5+2*PHASES-1];
    assign ov_s = sync_r[5+2*PHASES-2];
    assign react_s = sync_r[5+2*PHASES-3];
    assign skip_s = sync_r[5+2*PHASES-4];
    assign peak_s = sync_r[2*PHASES-1:PHASES];
    assign lim_s = sync_r[PHASES-1:0];

    // ------------------------------------------------------------
    // sync edge debounce
    // ------------------------------------------------------------
    logic deb_level_r; // accepted level of the sync input
    logic [1:0] deb_cnt_r; // cycles the new level has held
    logic ext_edge; // accepted edge of chosen polarity

    // a new level must hold two cycles before it is accepted;
    // this rejects single-cycle glitches at the cost of one cycle delay
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            deb_level_r <= 1'b0;
            deb_cnt_r <= 2'h0;
        end
        else if (sync_s == deb_level_r)
            deb_cnt_r <= 2'h0;
        else if (deb_cnt_r == 2'(DEB_CYC - 1))
        begin
            deb_level_r <= sync_s;
            deb_cnt_r <= 2'h0;
        end
        else
            deb_cnt_r <= deb_cnt_r + 2'h1;
    end

    // rising edge when invert is 0, falling when 1
    assign ext_edge = (sync_s != deb_level_r) && (deb_cnt_r == 2'(DEB_CYC - 1)) &&
        (sync_s != sync_edge_invert);

    // ------------------------------------------------------------
    // internal fail-safe pwm timebase
    // ------------------------------------------------------------
    logic [PER_W-1:0] fs_period; // period chosen by frequency code
    logic [PER_W-1:0] fs_cnt_r; // fail-safe period counter
    logic fs_tick; // fail-safe cycle start

    // code 0 is slowest, code 7 fastest, linear steps between
    assign fs_period = PER_W'(FS_PER_MAX_CYC - (int'(fail_safe_pwm_frequency) *
        (FS_PER_MAX_CYC - FS_PER_MIN_CYC)) / ((1 << FSF_W) - 1));
    assign fs_tick = (fs_cnt_r == '0);

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            fs_cnt_r <= '0;
        else if (!fail_safe_mode || fs_cnt_r >= fs_period - PER_W'(1))
            fs_cnt_r <= '0;
        else
            fs_cnt_r <= fs_cnt_r + PER_W'(1);
    end

    // ------------------------------------------------------------
    // cycle source and measured period
    // ------------------------------------------------------------
    logic cycle_start; // start of a pwm cycle
    logic [PER_W-1:0] per_cnt_r; // cycles since last start
    logic [PER_W-1:0] period_r; // last measured period

    assign cycle_start = fail_safe_mode ? fs_tick : ext_edge;

    // the external period is measured so minimum off-time can cap duty;
    // the counter saturates, so a stalled sync never wraps
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            per_cnt_r <= '0;
            period_r <= '1;
        end
        else if (cycle_start)
        begin
            per_cnt_r <= PER_W'(1);
            period_r <= fail_safe_mode ? fs_period : per_cnt_r;
        end
        else if (per_cnt_r != '1)
            per_cnt_r <= per_cnt_r + PER_W'(1);
    end

    // ------------------------------------------------------------
    // overvoltage handling
    // ------------------------------------------------------------
    logic ov_active_r; // pulses blocked by overvoltage
    logic ov_nxt; // next value of the block

    // hold off from trip until the rail drops under threshold - hysteresis
    always_comb
    begin
        ov_nxt = ov_active_r;
        if (ov_s)
            ov_nxt = 1'b1;
        else if (ov_active_r && react_s)
            ov_nxt = 1'b0;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            ov_active_r <= 1'b0;
        else
            ov_active_r <= ov_nxt;
    end

    // latched flag: a new trip wins over a status read clear
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            overvoltage_flag <= 1'b0;
        else if (ov_s)
            overvoltage_flag <= 1'b1;
        else if (status_read && !ov_active_r)
            overvoltage_flag <= 1'b0;
    end

    // ------------------------------------------------------------
    // phases
    // ------------------------------------------------------------
    logic allow; // gate permitted this cycle
    logic skip_now; // skip comparator suppresses pulses
    logic duty_req; // loop wants a pulse

    assign skip_now = (skip_cycle_select != SKIP_OFF) && skip_s;
    assign allow = boost_enable && !ov_active_r && !ov_s;
    assign duty_req = !skip_now;

    genvar gi;
    generate
        for (gi = 0; gi < PHASES; gi++)
        begin : g_phase
            bgpwm_phase u_phase (
                .ref_clk(ref_clk),
                .rst(rst),
                .cycle_start(cycle_start),
                .period_cyc(period_r),
                .min_on_time_select(min_on_time_select),
                .min_off_time_select(min_off_time_select),
                .allow(allow),
                .duty_req(duty_req),
                .peak_reached(peak_s[gi]),
                .limit_trip(lim_s[gi]),
                .gate(gate[gi])
            );
        end
    endgenerate

    // running flags drop with an overvoltage and return after recovery
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            phase_running_flag <= '0;
        else if (ov_s || ov_nxt)
            phase_running_flag <= '0;
        else
            phase_running_flag <= {PHASES{boost_enable}};
    end

    // ------------------------------------------------------------
    // settings registered out to the analog side
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            voltage_target_out <= VTGT_RST;
            ov_threshold_out <= '0;
            ov_hysteresis_out <= '0;
            limit_select_out <= '0;
            slope_select_out <= SLOPE_OFF;
            slope_ramp_enable <= 1'b0;
            skip_select_out <= SKIP_OFF;
        end
        else
        begin
            voltage_target_out <= boost_voltage_target;
            ov_threshold_out <= overvoltage_threshold;
            ov_hysteresis_out <= overvoltage_reactivation_hysteresis;
            limit_select_out <= phase_current_limit_select;
            slope_select_out <= slope_compensation_select;
            slope_ramp_enable <= (slope_compensation_select != SLOPE_OFF);
            skip_select_out <= skip_cycle_select;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_ov_trip;
        ov_s ##1 1'b1;
    endsequence

    chk_ov_gate_off: assert property (@(posedge ref_clk) disable iff (rst)
        s_ov_trip |=> gate == '0)
        else $error("gate on after overvoltage");

    chk_ov_flags: assert property (@(posedge ref_clk) disable iff (rst)
        ov_s |=> overvoltage_flag && phase_running_flag == '0)
        else $error("flags wrong after overvoltage");

    chk_ov_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (ov_active_r && !react_s && !ov_s) |=> ov_active_r)
        else $error("released before reactivation level");

    chk_ov_latched: assert property (@(posedge ref_clk) disable iff (rst)
        (overvoltage_flag && !status_read) |=> overvoltage_flag)
        else $error("overvoltage flag lost without read");

    chk_ov_blocked: assert property (@(posedge ref_clk) disable iff (rst)
        ov_active_r |=> phase_running_flag == '0 || !ov_active_r)
        else $error("running flags set during overvoltage");

    chk_target_copy: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1 |=> voltage_target_out == $past(boost_voltage_target))
        else $error("voltage target not held");

    chk_fs_source: assert property (@(posedge ref_clk) disable iff (rst)
        (fail_safe_mode && fs_tick) |-> cycle_start)
        else $error("fail-safe tick not used");

    chk_edge_debounce: assert property (@(posedge ref_clk) disable iff (rst)
        ext_edge |-> sync_s == $past(sync_s))
        else $error("edge accepted without two stable cycles");

    chk_slope_off: assert property (@(posedge ref_clk) disable iff (rst)
        (slope_compensation_select == SLOPE_OFF) |=> !slope_ramp_enable)
        else $error("ramp on with disable code");

endmodule // bgpwm_ctrl

/* bgpwm_phase.sv */
// one gate phase: on-time, minimum on/off time and per-cycle cut-off
`timescale 1ns/1ps
module bgpwm_phase
    import bgpwm_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // timing
    input wire logic cycle_start,
    input wire logic [PER_W-1:0] period_cyc,
    input wire logic [MINT_W-1:0] min_on_time_select,
    input wire logic [MINT_W-1:0] min_off_time_select,
    // gating
    input wire logic allow,
    input wire logic duty_req,
    input wire logic peak_reached,
    input wire logic limit_trip,
    // output
    output logic gate
);

    bgpwm_state_t state_r; // pulse state
    logic [PER_W-1:0] cnt_r; // cycles since pulse start
    logic [PER_W-1:0] on_max; // latest allowed on-cycle
    logic [PER_W-1:0] on_min; // least on cycles

    // ------------------------------------------------------------
    // duty limits
    // ------------------------------------------------------------
    // max on-time is the period less the minimum off-time
    assign on_max = (period_cyc > PER_W'(min_off_time_select) + PER_W'(1)) ?
        PER_W'(period_cyc - PER_W'(min_off_time_select)) : PER_W'(1);
    assign on_min = PER_W'(min_on_time_select) + PER_W'(1);

    // ------------------------------------------------------------
    // pulse state machine
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= BGPWM_IDLE;
            cnt_r <= '0;
        end
        else
        begin
            case (state_r)
                BGPWM_IDLE:
                begin
                    // zero duty requested: no pulse at all
                    if (cycle_start && allow && duty_req)
                    begin
                        state_r <= BGPWM_ON;
                        cnt_r <= PER_W'(1);
                    end
                end
                BGPWM_ON:
                begin
                    cnt_r <= cnt_r + PER_W'(1);
                    // hard stops win over the minimum on-time
                    if (!allow || limit_trip)
                        state_r <= BGPWM_OFF;
                    else if (cycle_start)
                    begin
                        // a new cycle while still on restarts the pulse when duty_req is set, so a zero
                        // minimum off-time never drops every other cycle
                        state_r <= duty_req ? BGPWM_ON : BGPWM_OFF;
                        cnt_r <= PER_W'(1);
                    end
                    else if (cnt_r >= on_max)
                        state_r <= BGPWM_OFF;
                    else if (peak_reached && cnt_r >= on_min)
                        state_r <= BGPWM_OFF;
                end
                BGPWM_OFF:
                begin
                    // wait for the next cycle start
                    if (cycle_start && allow && duty_req)
                    begin
                        state_r <= BGPWM_ON;
                        cnt_r <= PER_W'(1);
                    end
                    else
                        state_r <= BGPWM_OFF;
                end
                default:
                    state_r <= BGPWM_IDLE;
            endcase
        end
    end

    // gate registered from state
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            gate <= 1'b0;
        else
            gate <= (state_r == BGPWM_ON) && allow && !limit_trip;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_limit_cut: assert property (@(posedge ref_clk) disable iff (rst)
        limit_trip |=> !gate)
        else $error("gate stayed on after current limit");

    chk_no_duty: assert property (@(posedge ref_clk) disable iff (rst)
        (state_r == BGPWM_IDLE && !duty_req) |=> state_r != BGPWM_ON)
        else $error("pulse started with zero duty");

endmodule // bgpwm_phase

/* bgpwm_pkg.sv */
// package: constants for the boost gate pwm control block
package bgpwm_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10000000;               // system clock rate
    localparam int FS_FREQ_MIN_KHZ = 200;           // slowest fail-safe pwm
    localparam int FS_FREQ_MAX_KHZ = 1000;          // fastest fail-safe pwm
    // period in cycles for the slowest and fastest fail-safe settings
    localparam int FS_PER_MAX_CYC = CLK_HZ / (FS_FREQ_MIN_KHZ * 1000);
    localparam int FS_PER_MIN_CYC = CLK_HZ / (FS_FREQ_MAX_KHZ * 1000);
    localparam int FS_PER_STEP_CYC = (FS_PER_MAX_CYC - FS_PER_MIN_CYC) / 7;
    localparam int PER_W = 8;                       // period counter width

    // ------------------------------------------------------------
    // field widths and reset values
    // ------------------------------------------------------------
    localparam int VTGT_W = 7;                      // voltage target code width
    localparam int OVTH_W = 7;                      // overvoltage threshold width
    localparam int HYST_W = 2;                      // reactivation hysteresis width
    localparam int LIM_W = 2;                       // current limit select width
    localparam int SLOPE_W = 3;                     // slope compensation width
    localparam int FSF_W = 3;                       // fail-safe frequency width
    localparam int MINT_W = 3;                      // min on/off time width
    localparam int SKIP_W = 2;                      // skip select width
    localparam logic [6:0] VTGT_RST = 7'h00;        // minimum target at reset
    localparam logic [2:0] SLOPE_OFF = 3'h0;        // code that disables the ramp
    localparam logic [1:0] SKIP_OFF = 2'h0;         // code that disables skipping
    localparam logic SYNC_EDGE_RST = 1'b0;          // rising edge after reset
    localparam int DEB_CYC = 2;                     // sync edge debounce cycles

    // pwm phase state
    typedef enum logic [1:0]
    {
        BGPWM_IDLE = 2'b00,
        BGPWM_ON = 2'b01,
        BGPWM_OFF = 2'b10
    } bgpwm_state_t;

endpackage

/* bgpwm_stage_model.sv */
// far-side model: sync clock source and per-phase peak current comparators
`timescale 1ns/1ps
module bgpwm_stage_model
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control from the bench
    input wire logic sync_on,
    input wire logic [7:0] sync_half,
    input wire logic [7:0] peak_delay,
    input wire logic [2:0] gate,
    // towards the block
    output logic external_sync_input = 1'b0,
    output logic [2:0] peak_reached = 3'h0
);
    logic [7:0] half_cnt_r = 8'h00; // cycles spent at the current sync level
    logic [7:0] on_cnt_r [3] = '{8'h00, 8'h00, 8'h00}; // cycles each gate is on
    // ------------------------------------------------------------
    // sync clock source
    // ------------------------------------------------------------
    // stands still low outside bursts; half of 5 or more keeps it at 1 MHz or less
    always @(negedge ref_clk)
    begin
        if (rst || !sync_on)
        begin
            external_sync_input <= 1'b0;
            half_cnt_r <= 8'h00;
        end
        else if (half_cnt_r + 8'h01 >= sync_half)
        begin
            external_sync_input <= !external_sync_input;
            half_cnt_r <= 8'h00;
        end
        else
        begin
            half_cnt_r <= half_cnt_r + 8'h01;
        end
    end
    // ------------------------------------------------------------
    // inductor current ramp
    // ------------------------------------------------------------
    // current only builds while the gate is on; delay 0 means never reaches peak
    always @(negedge ref_clk)
    begin
        for (int i = 0; i < 3; i++)
        begin
            on_cnt_r[i] <= gate[i] ? on_cnt_r[i] + 8'h01 : 8'h00;
            peak_reached[i] <= gate[i] && (peak_delay != 8'h00) && (on_cnt_r[i] + 8'h01 >= peak_delay);
        end
    end
endmodule // bgpwm_stage_model

/* tb.sv */
// self-checking testbench for the boost gate pwm control block
`timescale 1ns/1ps
module tb;
    import bgpwm_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b0; // booster enable
    logic [6:0] vtgt = 7'h00, ovth = 7'h00, vt_o, ovth_o;
    logic [1:0] hyst = 2'h0, skip = 2'h0, hyst_o, skip_o;
    logic [5:0] lim = 6'h00, lim_o;
    logic [2:0] slope = 3'h0, fsf = 3'h0, ton = 3'h0, toff = 3'h0, slope_o;
    logic fsm = 1'b0, inv = 1'b0, rd = 1'b0, ov = 1'b0, react = 1'b0, skip_lo = 1'b0;
    logic sync_on = 1'b0, ramp_o, ext_sync, ov_flag;
    logic [7:0] half = 8'h0A, pdel = 8'h03;
    logic [2:0] peak, trip = 3'h0, gate, run;
    int failures = 0, check_count = 0, cycles = 0, n, w;
    // ------------------------------------------------------------
    // clock, timeout and instances
    // ------------------------------------------------------------
    always #50 ref_clk = !ref_clk;
    // whole run is about 1000 cycles; twenty times that means a hang
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles >= 20000)
        begin
            failures++;
            finish_test();
        end
    end
    bgpwm_ctrl #(.PHASES(3)) u_dut (.ref_clk(ref_clk), .rst(rst), .boost_enable(en),
        .boost_voltage_target(vtgt), .overvoltage_threshold(ovth),
        .overvoltage_reactivation_hysteresis(hyst), .phase_current_limit_select(lim),
        .slope_compensation_select(slope), .fail_safe_mode(fsm), .fail_safe_pwm_frequency(fsf),
        .sync_edge_invert(inv), .min_on_time_select(ton), .min_off_time_select(toff),
        .skip_cycle_select(skip), .status_read(rd), .external_sync_input(ext_sync),
        .ov_above(ov), .ov_below_react(react), .peak_reached(peak), .limit_trip(trip),
        .skip_below(skip_lo), .voltage_target_out(vt_o), .ov_threshold_out(ovth_o),
        .ov_hysteresis_out(hyst_o), .limit_select_out(lim_o), .slope_select_out(slope_o),
        .slope_ramp_enable(ramp_o), .skip_select_out(skip_o), .gate(gate),
        .overvoltage_flag(ov_flag), .phase_running_flag(run));
    bgpwm_stage_model u_stage (.ref_clk(ref_clk), .rst(rst), .sync_on(sync_on), .sync_half(half),
        .peak_delay(pdel), .gate(gate), .external_sync_input(ext_sync), .peak_reached(peak));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge ref_clk);
    endtask
    // cycles until gate 0 is seen on, bounded
    task automatic wait_on(output int k);
        k = 0;
        while (gate[0] !== 1'b1 && k < 300)
        begin
            cyc(1);
            k++;
        end
    endtask
    // cycles gate 0 stays on, bounded
    task automatic width(output int k);
        k = 0;
        while (gate[0] === 1'b1 && k < 300)
        begin
            cyc(1);
            k++;
        end
    endtask
    // skips a pulse already in progress, then waits for the next rise
    task automatic next_on(output int k);
        k = 0;
        while (gate[0] === 1'b1 && k < 300)
        begin
            cyc(1);
            k++;
        end
        wait_on(k);
    endtask
    // number of cycles with any gate on over a window
    task automatic on_count(input int k, output int h);
        h = 0;
        repeat (k)
        begin
            cyc(1);
            h += (gate !== 3'h0);
        end
    endtask
    task automatic finish_test();
        if (failures == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_settings();
        check("reset_outs", {vt_o, gate, run, ov_flag}, 32'h0);
        on_count(60, n);
        check("gate_disabled", n, 0);
        vtgt = 7'h5A;
        ovth = 7'h64;
        hyst = 2'h3;
        lim = 6'h1B;
        cyc(3);
        check("target", vt_o, 7'h5A);
        check("ov_levels", {ovth_o, hyst_o}, {7'h64, 2'h3});
        check("limit_sel", lim_o, 6'h1B);
        for (int s = 0; s < 8; s++)
        begin
            slope = s[2:0];
            skip = s[1:0];
            cyc(3);
            check("slope", {slope_o, ramp_o}, {s[2:0], s != 0});
            check("skip_sel", skip_o, s[1:0]);
        end
        skip = SKIP_OFF;
    endtask
    // gate follows the chosen sync edge after sampling and debounce
    task automatic t_sync_edge();
        en = 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            inv = i[0];
            cyc(40);
            @(posedge ext_sync);
            cyc(1);
            wait_on(n);
            check("edge_lat", n >= 4 + 10 * i && n <= 6 + 10 * i, 1);
        end
        inv = SYNC_EDGE_RST;
    endtask
    // fast peak still gets the minimum on-time; limit cuts one phase only
    task automatic t_on_limit();
        ton = 3'h5;
        pdel = 8'h01;
        cyc(30);
        next_on(n);
        width(w);
        check("min_on", w >= 6 && w <= 8, 1);
        ton = 3'h7;
        pdel = 8'h00;
        half = 8'h14;
        cyc(45);
        wait_on(n);
        cyc(1);
        trip = 3'b001;
        cyc(4);
        check("limit_cut", gate[1:0], 2'b10);
        trip = 3'h0;
        toff = 3'h7;
        cyc(45);
        next_on(n);
        width(w);
        check("max_on", w >= 31 && w <= 33, 1);
        toff = 3'h0;
        ton = 3'h0;
        pdel = 8'h03;
    endtask
    // overvoltage blocks gating, latches the flag until a read after recovery
    task automatic t_ov();
        ov = 1'b1;
        cyc(4);
        check("ov_hit", {gate, run, ov_flag}, 7'h01);
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        on_count(80, n);
        check("ov_block", {n[7:0], run, ov_flag}, 12'h001);
        ov = 1'b0;
        react = 1'b1;
        cyc(4);
        check("ov_recov", {run, ov_flag}, 4'hF);
        wait_on(n);
        check("ov_resume", n < 60, 1);
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        cyc(3);
        check("ov_clear", ov_flag, 1'b0);
        react = 1'b0;
    endtask
    // skip suppresses pulses only while selected and below threshold
    task automatic t_skip();
        skip = 2'h1;
        skip_lo = 1'b1;
        // a pulse started just before skip took hold may still be running
        cyc(12);
        on_count(80, n);
        check("skip_on", n, 0);
        skip = SKIP_OFF;
        cyc(2);
        wait_on(n);
        check("skip_off", n < 60, 1);
        skip_lo = 1'b0;
    endtask
    // fail-safe runs from the internal timebase with the sync pin still
    task automatic t_failsafe();
        sync_on = 1'b0;
        fsm = 1'b1;
        for (int f = 0; f < 8; f += 7)
        begin
            fsf = f[2:0];
            cyc(120);
            next_on(n);
            width(w);
            wait_on(n);
            // codes step linearly from the slowest to the fastest period
            n += w - (FS_PER_MAX_CYC - f * (FS_PER_MAX_CYC - FS_PER_MIN_CYC) / 7);
            check("fs_period", n >= -1 && n <= 1, 1);
        end
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        sync_on = 1'b1;
        cyc(12);
        rst = 1'b0;
        t_settings();
        t_sync_edge();
        t_on_limit();
        t_ov();
        t_skip();
        t_failsafe();
        finish_test();
    end
endmodule // tb
